/* logic/ipf_pending.sv */
/*
 * interrupt pending flag register with wishbone classic slave, a mask
 * register and one level interrupt line.
 * assumes the timer and serial sources are one-cycle pulses on clk_i and
 * the two port 3 pins arrive asynchronously from the pad ring.
 */
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - port3 bit1 pin flag, write zero clears
// - port3 bit0 pin flag, write zero clears
// - watch timer flag, write zero clears
// - serial transfer flag, write zero clears
// - timer b flag, write zero clears
module ipf_pending #(
   parameter int ADDR_W = ipf_pkg::ADDR_W,          // wishbone address width
   parameter int DATA_W = ipf_pkg::DATA_W           // wishbone data width
) (
   input  wire logic              clk_i,            // core clock, 200 mhz
   input  wire logic              rst_i,            // synchronous reset, high
   // wishbone classic slave
   input  wire logic              cyc_i,            // bus cycle
   input  wire logic              stb_i,            // strobe
   input  wire logic              we_i,             // write enable
   input  wire logic [ADDR_W-1:0] adr_i,            // byte address
   input  wire logic [DATA_W/8-1:0] sel_i,          // byte lanes
   input  wire logic [DATA_W-1:0] dat_i,            // write data
   output logic      [DATA_W-1:0] dat_o,            // read data
   output logic                   ack_o,            // acknowledge
   // interrupt sources
   input  wire logic              port3_bit1_pin_i, // external pin, async
   input  wire logic              port3_bit0_pin_i, // external pin, async
   input  wire logic              watch_tick_i,     // watch timer request pulse
   input  wire logic              serial_done_i,    // serial transfer pulse
   input  wire logic              timer_b_i,        // timer b request pulse
   // interrupt line
   output logic                   irq_o             // unmasked flag pending
);

   // =====================================================================
   // elaboration checks
   // =====================================================================
   if (ADDR_W < 3) begin : g_bad_addr
      $error("ipf_pending: address too narrow for the register map");
   end
   if (DATA_W < ipf_pkg::FLAG_W || DATA_W % 8 != 0) begin : g_bad_data
      $error("ipf_pending: data width must hold the flags in whole bytes");
   end

   // =====================================================================
   // declarations
   // =====================================================================
   logic [1:0]              p3b1_sync_ff;           // pin 1 synchroniser
   logic [1:0]              p3b0_sync_ff;           // pin 0 synchroniser
   logic                    p3b1_prev_ff;           // last synced pin 1
   logic                    p3b0_prev_ff;           // last synced pin 0
   logic [7:0]              pend_ff;                // pending flags
   logic [7:0]              nxt_pend;               // next pending flags
   logic [7:0]              mask_ff;                // irq line enables
   logic [7:0]              set_vec;                // hardware set requests
   logic [7:0]              clr_vec;                // software clear requests
   logic                    ack_ff;                 // registered ack
   logic [DATA_W-1:0]       dat_ff;                 // registered read data
   logic                    req;                    // live bus request
   logic                    wr_take;                // write commits this edge
   logic [7:0]              adr_lo;                 // low address byte

   // decode helper: does the low address byte hit a register offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign adr_lo = 8'(adr_i);
   assign req    = cyc_i & stb_i;
   // the write lands on the edge where the master samples ack high
   assign wr_take = req & we_i & ack_ff & sel_i[0];

   // =====================================================================
   // pin synchronisers and edge detect
   // =====================================================================
   // pins are asynchronous: two flops before any logic looks at them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p3b1_sync_ff <= 2'h0;
         p3b0_sync_ff <= 2'h0;
      end else begin
         p3b1_sync_ff <= {p3b1_sync_ff[0], port3_bit1_pin_i};
         p3b0_sync_ff <= {p3b0_sync_ff[0], port3_bit0_pin_i};
      end
   end

   // previous synced level; only the second stage feeds the edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p3b1_prev_ff <= 1'b0;
         p3b0_prev_ff <= 1'b0;
      end else begin
         p3b1_prev_ff <= p3b1_sync_ff[1];
         p3b0_prev_ff <= p3b0_sync_ff[1];
      end
   end

   // =====================================================================
   // set and clear vectors
   // =====================================================================
   // a rising pin edge or a source pulse raises its flag
   always_comb begin
      set_vec = 8'h00;
      set_vec[ipf_pkg::BIT_P3B1]   = p3b1_sync_ff[1] & ~p3b1_prev_ff;
      set_vec[ipf_pkg::BIT_P3B0]   = p3b0_sync_ff[1] & ~p3b0_prev_ff;
      set_vec[ipf_pkg::BIT_WATCH]  = watch_tick_i;
      set_vec[ipf_pkg::BIT_SERIAL] = serial_done_i;
      set_vec[ipf_pkg::BIT_TMRB]   = timer_b_i;
   end

   // zeros in the written byte clear; ones leave the flag alone
   always_comb begin
      clr_vec = 8'h00;
      if (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING)) begin
         clr_vec = ~dat_i[7:0] & ipf_pkg::FLAG_MASK;
      end
   end

   // a set in the clearing cycle wins so no request is lost
   assign nxt_pend = ((pend_ff & ~clr_vec) | set_vec) & ipf_pkg::FLAG_MASK;

   // =====================================================================
   // registers
   // =====================================================================
   // sticky pending flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_ff <= ipf_pkg::PEND_RST;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // mask register, plain read/write of implemented bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_ff <= ipf_pkg::MASK_RST;
      end else if (wr_take && hit(adr_lo, ipf_pkg::OFS_MASK)) begin
         mask_ff <= dat_i[7:0] & ipf_pkg::FLAG_MASK;
      end
   end

   // =====================================================================
   // wishbone answer
   // =====================================================================
   // ack one cycle after the request, dropped the cycle after; this gives
   // a fixed two-edge answer and keeps read data coming from a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // read data captured with the ack; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= '0;
      end else if (req && !ack_ff && !we_i) begin
         if (hit(adr_lo, ipf_pkg::OFS_PENDING)) begin
            dat_ff <= {{(DATA_W-8){1'b0}}, pend_ff};
         end else if (hit(adr_lo, ipf_pkg::OFS_MASK)) begin
            dat_ff <= {{(DATA_W-8){1'b0}}, mask_ff};
         end else begin
            dat_ff <= '0;
         end
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;
   // level line: high while any unmasked flag stands
   assign irq_o = |(pend_ff & mask_ff);

   // =====================================================================
   // assertions
   // =====================================================================
   // a timer b pulse shows as pending on the next cycle
   AST_TMRB_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      timer_b_i |=> pend_ff[ipf_pkg::BIT_TMRB])
      else $error("timer b pulse did not set its flag");

   // serial pulse sets its flag
   AST_SERIAL_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      serial_done_i |=> pend_ff[ipf_pkg::BIT_SERIAL])
      else $error("serial pulse did not set its flag");

   // a zero written to the watch bit clears it unless a tick arrives
   AST_WATCH_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && !dat_i[ipf_pkg::BIT_WATCH]
       && !watch_tick_i) |=> !pend_ff[ipf_pkg::BIT_WATCH])
      else $error("write of zero failed to clear watch flag");

   // a held high pin sets its flag three cycles after the edge
   AST_P3B1_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (!port3_bit1_pin_i ##1 port3_bit1_pin_i [*3]) |=> pend_ff[ipf_pkg::BIT_P3B1])
      else $error("pin 1 edge did not reach its flag");

   AST_P3B0_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (!port3_bit0_pin_i ##1 port3_bit0_pin_i [*3]) |=> pend_ff[ipf_pkg::BIT_P3B0])
      else $error("pin 0 edge did not reach its flag");

   // flags never fall without a clearing write; ones written keep them
   AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(pend_ff & ~clr_vec)) |=> ((pend_ff & $past(pend_ff & ~clr_vec))
                                   == $past(pend_ff & ~clr_vec)))
      else $error("pending flag dropped without a clearing write");

   // ack is exactly one cycle wide and follows a request
   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> ($past(req) && !$past(ack_o)) ##1 !ack_o)
      else $error("ack not a single cycle after a request");

   // the line can only rise after a flag was set or a register written;
   // a rise from nowhere would point at a glitching flop or a miswire
   AST_IRQ_LINE: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_o) |-> $past(|set_vec || wr_take))
      else $error("interrupt line rose without a set or a write");

   // a watch tick shows as pending on the next cycle
   AST_WATCH_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      watch_tick_i |=> pend_ff[ipf_pkg::BIT_WATCH])
      else $error("watch tick did not set its flag");

   // each remaining flag: a zero written clears it unless its own set
   // arrives in the same cycle, in which case the set wins
   AST_P3B1_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && !dat_i[ipf_pkg::BIT_P3B1]
       && !set_vec[ipf_pkg::BIT_P3B1]) |=> !pend_ff[ipf_pkg::BIT_P3B1])
      else $error("write of zero failed to clear pin 1 flag");

   AST_P3B0_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && !dat_i[ipf_pkg::BIT_P3B0]
       && !set_vec[ipf_pkg::BIT_P3B0]) |=> !pend_ff[ipf_pkg::BIT_P3B0])
      else $error("write of zero failed to clear pin 0 flag");

   AST_SERIAL_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && !dat_i[ipf_pkg::BIT_SERIAL]
       && !serial_done_i) |=> !pend_ff[ipf_pkg::BIT_SERIAL])
      else $error("write of zero failed to clear serial flag");

   AST_TMRB_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && !dat_i[ipf_pkg::BIT_TMRB]
       && !timer_b_i) |=> !pend_ff[ipf_pkg::BIT_TMRB])
      else $error("write of zero failed to clear timer b flag");

   // a set colliding with a clearing write must leave the flag standing
   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(set_vec & clr_vec)) |=> ((pend_ff & $past(set_vec)) == $past(set_vec)))
      else $error("clearing write swallowed a set in the same cycle");

   // ones written to the pending register keep a standing flag
   AST_ONE_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_PENDING) && |(pend_ff & dat_i[7:0]))
      |=> ((pend_ff & $past(pend_ff & dat_i[7:0])) == $past(pend_ff & dat_i[7:0])))
      else $error("write of one dropped a pending flag");

   // read data is the flags as they stood at the taking edge, upper zero
   AST_RD_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && hit(adr_lo, ipf_pkg::OFS_PENDING))
      |-> (dat_o == DATA_W'($past(pend_ff))))
      else $error("pending read returned a wrong value");

   // the mask reads back as it stood at the taking edge
   AST_RD_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && hit(adr_lo, ipf_pkg::OFS_MASK))
      |-> (dat_o == DATA_W'($past(mask_ff))))
      else $error("mask read returned a wrong value");

   // a mask write lands whole, reserved bits forced to zero
   AST_MASK_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_take && hit(adr_lo, ipf_pkg::OFS_MASK))
      |=> (mask_ff == ($past(dat_i[7:0]) & ipf_pkg::FLAG_MASK)))
      else $error("mask write did not land");

   // no ack without a request on the edge before; a stray ack would
   // complete a cycle that this slave never took
   AST_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !req |=> !ack_o)
      else $error("ack raised without a request");

   // =====================================================================
   // cover points
   // =====================================================================
   // a source pulse landing on the clearing write
   COV_SET_CLR_SAME: cover property (@(posedge clk_i) disable iff (rst_i)
      timer_b_i && clr_vec[ipf_pkg::BIT_TMRB]);
   // the line rising
   COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
   // a read that finds flags standing
   COV_READ_PEND: cover property (@(posedge clk_i) disable iff (rst_i)
      ack_o && !we_i && hit(adr_lo, ipf_pkg::OFS_PENDING) && (pend_ff != 8'h00));
   // a synchronised pin edge raising its flag
   COV_PIN_EDGE: cover property (@(posedge clk_i) disable iff (rst_i)
      set_vec[ipf_pkg::BIT_P3B1] || set_vec[ipf_pkg::BIT_P3B0]);
   // a partial clear that leaves some flags standing
   COV_PARTIAL_CLR: cover property (@(posedge clk_i) disable iff (rst_i)
      (|clr_vec) && (|(pend_ff & ~clr_vec)));

endmodule : ipf_pending

/* logic/ipf_pkg.sv */
/*
 * constants for the interrupt pending flag block: register offsets,
 * flag bit positions, reset values and bus widths.
 * assumes a single core clock and a classic wishbone register bus.
 */
package ipf_pkg;

   // =====================================================================
   // bus geometry
   // =====================================================================
   localparam int          ADDR_W      = 8;        // byte address width
   localparam int          DATA_W      = 32;       // wishbone data width
   localparam int          FLAG_W      = 8;        // pending register width

   // =====================================================================
   // register offsets (byte addresses)
   // =====================================================================
   localparam logic [7:0]  OFS_PENDING = 8'h00;    // pending flags
   localparam logic [7:0]  OFS_MASK    = 8'h04;    // interrupt line mask

   // =====================================================================
   // flag bit positions
   // =====================================================================
   localparam int          BIT_TMRB    = 0;        // timer b
   localparam int          BIT_SERIAL  = 1;        // serial_io_unit transfer
   localparam int          BIT_WATCH   = 2;        // watch timer
   localparam int          BIT_P3B0    = 3;        // port3_bit0_pin
   localparam int          BIT_P3B1    = 4;        // port3_bit1_pin
   localparam int          NUM_FLAGS   = 5;        // implemented flags

   // implemented bits; bits 7..5 read as zero
   localparam logic [7:0]  FLAG_MASK   = 8'h1F;
   localparam logic [7:0]  PEND_RST    = 8'h00;    // nothing pending at reset
   localparam logic [7:0]  MASK_RST    = 8'h00;    // line masked at reset

endpackage : ipf_pkg

/* verif/interrupt_pending_flags_bench.sv */
/* self-checking bench for the pending flag block: wishbone tasks, source
 * pulses and an integer model. assumes ipf_pkg and ipf_pending are compiled first. */
`timescale 1ns/1ps
module interrupt_pending_flags_bench;
   // =====================================================================
   // signals
   // =====================================================================
   logic        clk_i = 1'b0;              // 200 mhz core clock
   logic        rst_i = 1'b1;              // synchronous reset
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;             // byte address
   logic [3:0]  sel_i = 4'hF;              // byte lanes
   logic [31:0] dat_i = 32'h00000000;      // write data
   logic [31:0] dat_o;                     // read data
   logic        ack_o, irq_o;
   logic [4:0]  src = 5'h00;               // sources, indexed by flag bit
   int          mismatches = 0, checks_done = 0;
   int          pend = 0, mask = 0;        // model registers
   logic [15:0] rnd = 16'hAC24;            // lfsr state, seed 44068
   logic [31:0] rd;                        // last read word
   always #2.5 clk_i = ~clk_i;
   ipf_pending u_ipf_pending (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .port3_bit1_pin_i(src[ipf_pkg::BIT_P3B1]), .port3_bit0_pin_i(src[ipf_pkg::BIT_P3B0]),
      .watch_tick_i(src[ipf_pkg::BIT_WATCH]), .serial_done_i(src[ipf_pkg::BIT_SERIAL]),
      .timer_b_i(src[ipf_pkg::BIT_TMRB]), .irq_o(irq_o));
   // =====================================================================
   // helpers
   // =====================================================================
   // galois lfsr step, taps 16,14,13,11
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      lfsr = x[0] ? ((x >> 1) ^ 16'hB400) : (x >> 1);
   endfunction : lfsr
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic finish_test;
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   // one classic cycle; holds everything until ack is seen at an edge,
   // and only the watchdog ends a wait that never sees it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;                          // read data taken at the ack edge
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);                    // idle cycle, line settles
      check("ack", 32'h00000000, 32'(ack_o)); // ack stands one cycle only
   endtask : wb
   // model update for a pending write: zero clears, one keeps
   task automatic wr_pend(input logic [7:0] v);
      wb(1'b1, ipf_pkg::OFS_PENDING, {24'h000000, v});
      pend = pend & int'(v);
   endtask : wr_pend
   task automatic wr_mask(input logic [7:0] v);
      wb(1'b1, ipf_pkg::OFS_MASK, {24'h000000, v});
      mask = int'(v & ipf_pkg::FLAG_MASK);
   endtask : wr_mask
   task automatic rd_check;
      wb(1'b0, ipf_pkg::OFS_PENDING, 32'h00000000);
      check("pending", 32'(pend), rd);
      check("irq", 32'((pend & mask) != 0), 32'(irq_o));
   endtask : rd_check
   // raise sources for a few cycles; pins need a held rising edge
   task automatic fire(input logic [4:0] v);
      src <= v;
      repeat (5) @(posedge clk_i);
      src <= 5'h00;
      repeat (5) @(posedge clk_i);
      pend = pend | int'(v);
   endtask : fire
   // =====================================================================
   // watchdog
   // =====================================================================
   initial begin
      #(5 * 20000);
      mismatches++;
      finish_test();
   end
   // =====================================================================
   // main sequence
   // =====================================================================
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_check();                          // reset values
      wb(1'b0, ipf_pkg::OFS_MASK, 32'h00000000);
      check("mask", 32'h00000000, rd);
      // each source alone: set, survives a write of ones, cleared by zero
      for (int b = 0; b < ipf_pkg::NUM_FLAGS; b++) begin
         fire(5'(1 << b));
         rd_check();
         wr_pend(8'hFF);
         rd_check();
         wr_mask(8'(1 << b));
         rd_check();
         wr_pend(8'(~(1 << b)));
         rd_check();
      end
      // unmapped place: acked, reads zero, write ignored
      fire(5'h1F);
      wb(1'b1, 8'h08, 32'h00000000);
      wb(1'b0, 8'h08, 32'h00000000);
      check("unmapped", 32'h00000000, rd);
      rd_check();
      // timer b held through a clearing write: the set wins
      src <= 5'h01;
      wr_pend(8'h00);
      src <= 5'h00;
      pend = pend | 1;
      rd_check();
      // a write with byte lane 0 off is ignored
      sel_i <= 4'hE;
      wb(1'b1, ipf_pkg::OFS_PENDING, 32'h00000000);
      sel_i <= 4'hF;
      rd_check();
      // random mix of sources, partial clears and masks
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         fire(rnd[4:0]);
         wr_mask(rnd[12:5]);
         wb(1'b0, ipf_pkg::OFS_MASK, 32'h00000000);
         check("mask", 32'(mask), rd);
         rd_check();
         rnd = lfsr(rnd);
         wr_pend(rnd[7:0]);
         rd_check();
      end
      finish_test();
   end
endmodule : interrupt_pending_flags_bench
